// >>> hw/gccr_top.sv
// General control and clock recovery control registers with their side effects
//
// Functional notes
// RULE_01 - General bit 6 enables interrupt pin
// RULE_02 - Bit 5: status latches on one-second edge
// RULE_03 - Bit 4: counters latch on one-second edge
// RULE_04 - Bit 3 set: one count per errored frame
// RULE_05 - Bit 3 clear: add all frame errors
// RULE_06 - Bit 2 set: pins show output register
// RULE_07 - Bit 2 clear: pins show alarms
// RULE_08 - Any data link enable overrides pin source
// RULE_09 - Bit 1: reset machines, keep registers
// RULE_10 - Bit 0: hold reset, registers to defaults
// RULE_11 - Software writes zero to reserved bit 7
// RULE_12 - Clock bit 7 inverts transmit clock
// RULE_13 - Bit 6 picks receive edge, external only
// RULE_14 - Bit 5 bypasses internal clock recovery
// RULE_15 - Bits 4:3 select transmit clock source
// RULE_16 - Bit 2 enables source loopback
// RULE_17 - Bit 1 enables line loopback
// RULE_18 - Bit 0 loops cell bus, floats pins
// RULE_19 - Latching covers status and counter registers
// RULE_20 - Reset bits clear themselves
`timescale 1ns/1ps
`include "gccr_params.svh"

module gccr_top #(
	parameter int ERR_W = 8
) (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// Parallel register port pins
	input  wire logic                  cs_n,
	input  wire logic                  rd_n,
	input  wire logic                  wr_n,
	input  wire logic [6:0]            addr,
	input  wire logic [7:0]            data_in,
	output logic      [7:0]            data_out,
	output logic                       data_oe,
	// One-second pin and latch strobes
	input  wire logic                  one_second_pulse_in,
	output logic                       status_latch_update,
	output logic                       counter_latch_update,
	// Interrupt request and pin
	input  wire logic                  irq_request,
	output logic                       irq_out_n,
	// Per-frame error figures and counter steps
	input  wire logic                  frame_done,
	input  wire logic [ERR_W-1:0]      section_parity_errors,
	input  wire logic [ERR_W-1:0]      line_parity_errors,
	input  wire logic [ERR_W-1:0]      path_parity_errors,
	input  wire logic [ERR_W-1:0]      line_far_end_errors,
	input  wire logic [ERR_W-1:0]      path_far_end_errors,
	output logic                       count_step_valid,
	output logic      [ERR_W-1:0]      section_parity_error_step,
	output logic      [ERR_W-1:0]      line_parity_error_step,
	output logic      [ERR_W-1:0]      path_parity_error_step,
	output logic      [ERR_W-1:0]      line_far_end_error_step,
	output logic      [ERR_W-1:0]      path_far_end_error_step,
	// Status pin sources
	input  wire logic [7:0]            output_pin_value,
	input  wire logic [7:0]            alarm_status,
	input  wire logic [7:0]            link_pin_value,
	input  wire logic                  tx_section_link_enable,
	input  wire logic                  tx_line_link_enable,
	input  wire logic                  rx_section_link_enable,
	input  wire logic                  rx_line_link_enable,
	output logic      [7:0]            status_pins,
	// Resets for the rest of the device
	output logic                       state_machine_reset,
	output logic                       register_default_load,
	// Clock recovery and loopback controls
	output logic                       tx_clock_invert,
	output logic                       rx_sample_falling,
	output logic                       external_recovery_enable,
	output gccr_pkg::gccr_txsrc_t      tx_clock_source,
	output logic                       source_loopback,
	output logic                       line_loopback,
	output logic                       cell_bus_loopback,
	output logic                       cell_bus_drive_enable
);
	import gccr_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (ERR_W < 1 || ERR_W > 16) begin : g_bad_width
		$error("ERR_W must lie between 1 and 16");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Step for one counter: one per errored frame or the full figure
	function automatic logic [ERR_W-1:0] err_step(input logic [ERR_W-1:0] n,
		input logic blk);
		err_step = blk ? ERR_W'(n != '0) : n;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [18:0] pin_sync;        // Synchronised pin group
	logic [18:0] pin_dly_r;       // One cycle older copy
	logic        wr_fire;         // End of a host write
	logic        rd_active;       // Host read in progress
	logic        sec_rise;        // Rising edge of one-second pin
	logic        hit_gen_w;       // Write aimed at general control
	logic        hit_clk_w;       // Write aimed at clock control
	logic [7:0]  wdata;           // Data of the finishing write
	logic [6:0]  waddr;           // Address of the finishing write

	gccr_sync #(
		.W    (19),
		.INIT (`GCCR_SYNC_INIT)
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.pin_in   ({one_second_pulse_in, cs_n, rd_n, wr_n, addr, data_in}),
		.sync_out (pin_sync)
	);

	// Delayed copy for edge detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pin_dly_r <= `GCCR_SYNC_INIT;
		else
			pin_dly_r <= pin_sync;
	end

	// Write is taken on the rising edge of the write strobe
	assign wr_fire   = pin_sync[15] & ~pin_dly_r[15] & ~pin_dly_r[17];
	assign waddr     = pin_dly_r[14:8];
	assign wdata     = pin_dly_r[7:0];
	assign hit_gen_w = wr_fire & (waddr == `GCCR_OFS_GENERAL);
	assign hit_clk_w = wr_fire & (waddr == `GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL);
	assign rd_active = ~pin_sync[17] & ~pin_sync[16];
	assign sec_rise  = pin_sync[18] & ~pin_dly_r[18];

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [7:0] gen_r;            // General control
	logic [7:0] clk_r;            // Clock recovery and loopback control
	logic [7:0] gen_nxt;
	logic [7:0] clk_nxt;
	logic       master_req;       // Master reset bit currently set

	assign master_req = gen_r[`GCCR_GEN_MASTER_RST];

	// Next values; reset bits clear themselves one cycle after the write
	always_comb begin
		gen_nxt = gen_r;
		clk_nxt = clk_r;
		gen_nxt[`GCCR_GEN_LOGIC_RST]  = 1'b0;                        // [RULE_20]
		gen_nxt[`GCCR_GEN_MASTER_RST] = 1'b0;                        // [RULE_20]
		if (master_req) begin
			gen_nxt = `GCCR_GEN_RESET;                               // [RULE_10]
			clk_nxt = `GCCR_CLOCK_RECOVERY_LOOPBACK_CONTROL_RESET;                            // [RULE_10]
		end else begin
			if (hit_gen_w)
				gen_nxt = wdata;
			if (hit_clk_w)
				clk_nxt = wdata;
		end
	end

	// Register state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gen_r <= `GCCR_GEN_RESET;
			clk_r <= `GCCR_CLOCK_RECOVERY_LOOPBACK_CONTROL_RESET;
		end else begin
			gen_r <= gen_nxt;
			clk_r <= clk_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;           // Read data selection
	logic       rd_hit;           // Read aimed at this bank

	assign rd_hit = (pin_sync[14:8] == `GCCR_OFS_GENERAL) |
		(pin_sync[14:8] == `GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL);
	assign rd_mux = (pin_sync[14:8] == `GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL) ? clk_r : gen_r;

	// Read data held in a flop; the bus is driven only for our offsets
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else begin
			data_out <= rd_mux;
			data_oe  <= rd_active & rd_hit;
		end
	end

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	gccr_state_t state_r;
	gccr_state_t state_nxt;
	logic [3:0]  rst_cnt_r;
	logic [3:0]  rst_cnt_nxt;

	// Master reset wins over a logic reset written at the same time
	always_comb begin
		state_nxt   = state_r;
		rst_cnt_nxt = rst_cnt_r;
		case (state_r)
			GCCR_IDLE: begin
				rst_cnt_nxt = 4'h0;
			end
			GCCR_LOGIC: begin
				rst_cnt_nxt = rst_cnt_r + 4'h1;
				if (rst_cnt_r == 4'(`GCCR_LOGIC_RST_CYCLES - 1))
					state_nxt = GCCR_IDLE;
			end
			GCCR_MASTER: begin
				rst_cnt_nxt = rst_cnt_r + 4'h1;
				if (rst_cnt_r == 4'(`GCCR_MASTER_RST_CYCLES - 1))
					state_nxt = GCCR_IDLE;
			end
			default: begin
				state_nxt = GCCR_IDLE;
			end
		endcase
		if (master_req) begin
			state_nxt   = GCCR_MASTER;                               // [RULE_10]
			rst_cnt_nxt = 4'h0;
		end else if (gen_r[`GCCR_GEN_LOGIC_RST]) begin
			state_nxt   = GCCR_LOGIC;                                // [RULE_09]
			rst_cnt_nxt = 4'h0;
		end
	end

	// Sequencer state and reset outputs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r               <= GCCR_IDLE;
			rst_cnt_r             <= 4'h0;
			state_machine_reset   <= 1'b0;
			register_default_load <= 1'b0;
		end else begin
			state_r               <= state_nxt;
			rst_cnt_r             <= rst_cnt_nxt;
			state_machine_reset   <= (state_nxt != GCCR_IDLE);       // [RULE_09]
			register_default_load <= (state_nxt == GCCR_MASTER);     // [RULE_10]
		end
	end

	// ----------------------------------------------------------------
	// Interrupt, latching, error steps and status pins
	// ----------------------------------------------------------------
	logic link_override;          // Any data link enable set

	assign link_override = tx_section_link_enable | tx_line_link_enable |
		rx_section_link_enable | rx_line_link_enable;

	// Registered outputs driven from the control bits
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_out_n                 <= 1'b1;
			status_latch_update       <= 1'b0;
			counter_latch_update      <= 1'b0;
			count_step_valid          <= 1'b0;
			section_parity_error_step <= '0;
			line_parity_error_step    <= '0;
			path_parity_error_step    <= '0;
			line_far_end_error_step   <= '0;
			path_far_end_error_step   <= '0;
			status_pins               <= 8'h00;
		end else begin
			irq_out_n <= ~(gen_r[`GCCR_GEN_IRQ_EN] & irq_request);   // [RULE_01]
			// Latched registers follow the strobe; level when latching off
			status_latch_update  <= gen_r[`GCCR_GEN_STAT_LAT] ?
				sec_rise : 1'b1;                                     // [RULE_02] [RULE_19]
			counter_latch_update <= gen_r[`GCCR_GEN_CNTR_LAT] ?
				sec_rise : 1'b1;                                     // [RULE_03] [RULE_19]
			count_step_valid     <= frame_done;
			if (frame_done) begin
				// [RULE_04] [RULE_05]
				section_parity_error_step <= err_step(section_parity_errors,
					gen_r[`GCCR_GEN_BLK_MODE]);
				line_parity_error_step    <= err_step(line_parity_errors,
					gen_r[`GCCR_GEN_BLK_MODE]);
				path_parity_error_step    <= err_step(path_parity_errors,
					gen_r[`GCCR_GEN_BLK_MODE]);
				line_far_end_error_step   <= err_step(line_far_end_errors,
					gen_r[`GCCR_GEN_BLK_MODE]);
				path_far_end_error_step   <= err_step(path_far_end_errors,
					gen_r[`GCCR_GEN_BLK_MODE]);
			end
			if (link_override)
				status_pins <= link_pin_value;                       // [RULE_08]
			else if (gen_r[`GCCR_GEN_PIN_SEL])
				status_pins <= output_pin_value;                     // [RULE_06]
			else
				status_pins <= alarm_status;                         // [RULE_07]
		end
	end

	// ----------------------------------------------------------------
	// Clock recovery and loopback controls
	// ----------------------------------------------------------------
	assign tx_clock_invert          = clk_r[`GCCR_CLK_TX_INV];      // [RULE_12]
	assign external_recovery_enable = clk_r[`GCCR_CLK_EXT_REC];     // [RULE_14]
	assign tx_clock_source          = gccr_txsrc_t'(
		clk_r[`GCCR_CLK_SEL_HI:`GCCR_CLK_SEL_LO]);                   // [RULE_15]
	assign source_loopback          = clk_r[`GCCR_CLK_SRC_LOOP];    // [RULE_16]
	assign line_loopback            = clk_r[`GCCR_CLK_LINE_LOOP];   // [RULE_17]
	assign cell_bus_loopback        = clk_r[`GCCR_CLK_CELL_LOOP];   // [RULE_18]
	assign cell_bus_drive_enable    = ~clk_r[`GCCR_CLK_CELL_LOOP];  // [RULE_18]

	// Falling receive edge only counts with external recovery
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rx_sample_falling <= 1'b0;
		else
			rx_sample_falling <= clk_nxt[`GCCR_CLK_RX_INV] &
				clk_nxt[`GCCR_CLK_EXT_REC];                          // [RULE_13]
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_logic_write;
		hit_gen_w && wdata[`GCCR_GEN_LOGIC_RST] && !wdata[`GCCR_GEN_MASTER_RST];
	endsequence

	sequence s_master_write;
		hit_gen_w && wdata[`GCCR_GEN_MASTER_RST];
	endsequence

	irq_gate_a: assert property (!gen_r[6] |=> irq_out_n) // [RULE_01]
		else $error("interrupt pin driven while disabled");
	stat_latch_a: assert property (gen_r[5] && !sec_rise |=> !status_latch_update) // [RULE_02]
		else $error("status latch strobe without one-second edge");
	cntr_latch_a: assert property (!gen_r[4] |=> counter_latch_update) // [RULE_03]
		else $error("counters not updating continuously");
	blk_count_a: assert property (frame_done && gen_r[3] |=> // [RULE_04]
		section_parity_error_step == ERR_W'($past(section_parity_errors) != '0))
		else $error("block mode step is not one per errored frame");
	full_count_a: assert property (frame_done && !gen_r[3] |=> // [RULE_05]
		path_far_end_error_step == $past(path_far_end_errors))
		else $error("full count step differs from frame errors");
	outstat_pins_a: assert property (gen_r[2] && !link_override |=> // [RULE_06]
		status_pins == $past(output_pin_value))
		else $error("status pins do not follow output register");
	alarm_pins_a: assert property (!gen_r[2] && !link_override |=> // [RULE_07]
		status_pins == $past(alarm_status))
		else $error("status pins do not show alarms");
	link_pins_a: assert property (link_override |=> status_pins == $past(link_pin_value)) // [RULE_08]
		else $error("data link enable did not override pins");
	logic_reset_a: assert property (s_logic_write ##1 1 |=> // [RULE_09]
		state_machine_reset[*4] ##0 $stable(clk_r))
		else $error("logic reset sequence wrong");
	master_reset_a: assert property (s_master_write |=> ##1 // [RULE_10]
		gen_r == 8'h00 && clk_r == 8'h00 ##1 register_default_load)
		else $error("master reset did not restore defaults");
	self_clear_a: assert property (gen_r[1:0] != 2'b00 |=> gen_r[1:0] == 2'b00) // [RULE_20]
		else $error("reset bits did not clear themselves");
	cell_hiz_a: assert property (cell_bus_loopback |-> !cell_bus_drive_enable) // [RULE_18]
		else $error("cell bus driven during loopback");
	rx_edge_a: assert property (!clk_r[5] |-> !rx_sample_falling) // [RULE_13]
		else $error("receive edge changed with internal recovery");
endmodule

// >>> inc/gccr_params.svh
// Offsets, field positions, reset values and timing counts of the control bank
`ifndef GCCR_PARAMS_SVH
`define GCCR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GCCR_OFS_GENERAL        7'h00
`define GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL         7'h01

// ----------------------------------------------------------------
// General control fields
// ----------------------------------------------------------------
`define GCCR_GEN_RESERVED       7
`define GCCR_GEN_IRQ_EN         6
`define GCCR_GEN_STAT_LAT       5
`define GCCR_GEN_CNTR_LAT       4
`define GCCR_GEN_BLK_MODE       3
`define GCCR_GEN_PIN_SEL        2
`define GCCR_GEN_LOGIC_RST      1
`define GCCR_GEN_MASTER_RST     0

// ----------------------------------------------------------------
// Clock recovery and loopback fields
// ----------------------------------------------------------------
`define GCCR_CLK_TX_INV         7
`define GCCR_CLK_RX_INV         6
`define GCCR_CLK_EXT_REC        5
`define GCCR_CLK_SEL_HI         4
`define GCCR_CLK_SEL_LO         3
`define GCCR_CLK_SRC_LOOP       2
`define GCCR_CLK_LINE_LOOP      1
`define GCCR_CLK_CELL_LOOP      0

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define GCCR_GEN_RESET          8'h00
`define GCCR_CLOCK_RECOVERY_LOOPBACK_CONTROL_RESET       8'h00
`define GCCR_LOGIC_RST_CYCLES   4
`define GCCR_MASTER_RST_CYCLES  8
`define GCCR_SYNC_INIT          19'h38000

`endif

// >>> inc/gccr_pkg.sv
// Types shared by the control bank files
package gccr_pkg;

	// Reset sequencer states
	typedef enum logic [1:0] {
		GCCR_IDLE   = 2'b00,
		GCCR_LOGIC  = 2'b01,
		GCCR_MASTER = 2'b10
	} gccr_state_t;

	// Transmit clock source encoding
	typedef enum logic [1:0] {
		GCCR_TX_REF19M = 2'b00,
		GCCR_TX_LOOP   = 2'b01,
		GCCR_TX_REF8K  = 2'b10,
		GCCR_TX_155M   = 2'b11
	} gccr_txsrc_t;

endpackage

// >>> hw/gccr_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps

module gccr_sync #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	input  wire logic          clk,
	input  wire logic          reset_n,
	input  wire logic [W-1:0]  pin_in,
	output logic      [W-1:0]  sync_out
);
	// ----------------------------------------------------------------
	// Synchroniser stages
	// ----------------------------------------------------------------
	logic [W-1:0] meta_r;   // First stage, read only by the second

	// Two flops in series, constant reset value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r   <= INIT;
			sync_out <= INIT;
		end else begin
			meta_r   <= pin_in;
			sync_out <= meta_r;
		end
	end
endmodule

// >>> testbench/gccr_host.sv
// Host processor model that drives the parallel register port
`timescale 1ns/1ps
`include "gccr_params.svh"

module gccr_host (
	input  wire logic       clk,
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic [6:0]      addr,
	output logic [7:0]      data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe
);
	// ----------------------------------------------------------------
	// Idle bus at time zero
	// ----------------------------------------------------------------
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 7'h00;
		data_in = 8'h00;
	end

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// Write: write strobe low four edges, chip select eight, address and data held past the rise
	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == `GCCR_OFS_GENERAL) begin
			v[7] = 1'b0; // Reserved bit always written as zero
		end
		@(posedge clk);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		addr <= a;
		data_in <= v;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		// Released data lines no longer show the last value
		data_in <= ~v;
		repeat (4) @(posedge clk);
	endtask

	// Read: strobes held until data_oe is sampled high, bounded wait
	task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		for (int i = 0; i < 8 && !ok; i++) begin
			@(posedge clk);
			if (data_oe === 1'b1) begin
				ok = 1'b1;
				d = data_out;
			end
		end
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
endmodule

// >>> testbench/gccr_top_tb_top.sv
// Self-checking bench for the general and clock control registers
`timescale 1ns/1ps
`include "gccr_params.svh"

module gccr_top_tb_top;
	import gccr_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic             clk;
	logic             reset_n;
	logic             cs_n, rd_n, wr_n;
	logic [6:0]       addr;
	logic [7:0]       data_in, data_out;
	logic             data_oe;
	logic             one_sec, sl_upd, cl_upd;
	logic             irq_request, irq_out_n;
	logic             frame_done, count_step_valid;
	logic [7:0]       errs [5] = '{8'h03, 8'h00, 8'h07, 8'h01, 8'hff};
	logic [7:0]       steps [5];
	logic [3:0]       link_en;
	logic [7:0]       pin_vals [3] = '{8'ha3, 8'h5a, 8'h3c}; // Output reg, alarms, link
	logic [7:0]       status_pins;
	logic             smr, rdl;
	logic             txi, rxf, extr, srcl, linl, celll, cde;
	gccr_txsrc_t      txsrc;
	logic [7:0]       clk_tab [4] = '{8'he5, 8'h4a, 8'h92, 8'h39};
	logic [7:0]       v;
	logic             ok;
	int               err_total = 0;
	int               cmp_count = 0;
	int               smr_cnt = 0, rdl_cnt = 0, sl_cnt = 0, cl_cnt = 0;
	int               b0, b1, b2, b3;

	// ----------------------------------------------------------------
	// Design, host model and clock
	// ----------------------------------------------------------------
	gccr_top #(.ERR_W(8)) i_dut (.clk(clk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .one_second_pulse_in(one_sec), .status_latch_update(sl_upd),
		.counter_latch_update(cl_upd), .irq_request(irq_request), .irq_out_n(irq_out_n),
		.frame_done(frame_done), .section_parity_errors(errs[0]),
		.line_parity_errors(errs[1]), .path_parity_errors(errs[2]),
		.line_far_end_errors(errs[3]), .path_far_end_errors(errs[4]),
		.count_step_valid(count_step_valid), .section_parity_error_step(steps[0]),
		.line_parity_error_step(steps[1]), .path_parity_error_step(steps[2]),
		.line_far_end_error_step(steps[3]), .path_far_end_error_step(steps[4]),
		.output_pin_value(pin_vals[0]), .alarm_status(pin_vals[1]),
		.link_pin_value(pin_vals[2]),
		.tx_section_link_enable(link_en[3]), .tx_line_link_enable(link_en[2]),
		.rx_section_link_enable(link_en[1]), .rx_line_link_enable(link_en[0]),
		.status_pins(status_pins), .state_machine_reset(smr),
		.register_default_load(rdl), .tx_clock_invert(txi), .rx_sample_falling(rxf),
		.external_recovery_enable(extr), .tx_clock_source(txsrc),
		.source_loopback(srcl), .line_loopback(linl), .cell_bus_loopback(celll),
		.cell_bus_drive_enable(cde));
	gccr_host i_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Count cycles of the reset levels and the latch strobes
	always @(posedge clk) begin
		smr_cnt <= smr_cnt + int'(smr);
		rdl_cnt <= rdl_cnt + int'(rdl);
		sl_cnt <= sl_cnt + int'(sl_upd);
		cl_cnt <= cl_cnt + int'(cl_upd);
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Let n edges pass, then sample settled outputs
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Read a register and compare; a timed-out read ends the run
	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       k;
		i_host.read_reg(a, d, k);
		chk(k, 1'b1);
		chk(d, exp);
		if (k !== 1'b1) begin
			close_out();
		end
	endtask

	// One frame end, steps checked one cycle later
	task automatic frame_chk(input logic blk);
		@(posedge clk);
		frame_done <= 1'b1;
		@(posedge clk);
		frame_done <= 1'b0;
		#1;
		chk(count_step_valid, 1'b1);
		for (int j = 0; j < 5; j++) begin
			chk(steps[j], blk ? 8'(errs[j] != 0) : errs[j]);
		end
		step(1);
		chk(count_step_valid, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		one_sec = 1'b0;
		irq_request = 1'b0;
		frame_done = 1'b0;
		link_en = 4'h0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		step(3);
		chk(irq_out_n, 1'b1);
		chk(cde, 1'b1);
		chk({sl_upd, cl_upd}, 2'b11);
		rdchk(`GCCR_OFS_GENERAL, 8'h00);
		rdchk(`GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL, 8'h00);
		// Unmapped address leaves the data bus undriven
		i_host.read_reg(7'h05, v, ok);
		chk(ok, 1'b0);
		// Every transmit clock source with mixed control bits
		for (int k = 0; k < 4; k++) begin
			v = clk_tab[k];
			i_host.write_reg(`GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL, v);
			rdchk(`GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL, v);
			chk(txi, v[7]);
			chk(rxf, v[6] & v[5]);
			chk(extr, v[5]);
			chk(txsrc, v[4:3]);
			chk(srcl, v[2]);
			chk(linl, v[1]);
			chk({celll, cde}, {v[0], !v[0]});
		end
		// Interrupt pin gated by its enable
		@(posedge clk);
		irq_request <= 1'b1;
		step(3);
		chk(irq_out_n, 1'b1);
		i_host.write_reg(`GCCR_OFS_GENERAL, 8'h40);
		step(1);
		chk(irq_out_n, 1'b0);
		@(posedge clk);
		irq_request <= 1'b0;
		step(3);
		chk(irq_out_n, 1'b1);
		// Status pin sources and the link override
		chk(status_pins, 8'h5a);
		i_host.write_reg(`GCCR_OFS_GENERAL, 8'h44);
		step(1);
		chk(status_pins, 8'ha3);
		for (int e = 0; e < 4; e++) begin
			@(posedge clk);
			link_en <= 4'(1 << e);
			pin_vals[2] <= 8'h3c ^ 8'(e);
			step(3);
			chk(status_pins, 8'h3c ^ 8'(e));
		end
		@(posedge clk);
		link_en <= 4'h0;
		// Error steps, full count then one per errored frame
		frame_chk(1'b0);
		i_host.write_reg(`GCCR_OFS_GENERAL, 8'h4c);
		frame_chk(1'b1);
		// One-second latching strobes
		chk({sl_upd, cl_upd}, 2'b11);
		i_host.write_reg(`GCCR_OFS_GENERAL, 8'h7c);
		step(2);
		chk({sl_upd, cl_upd}, 2'b00);
		b0 = sl_cnt;
		b1 = cl_cnt;
		@(posedge clk);
		one_sec <= 1'b1;
		repeat (3) @(posedge clk);
		one_sec <= 1'b0;
		step(8);
		chk(sl_cnt - b0, 1);
		chk(cl_cnt - b1, 1);
		// Logic reset keeps registers and clears itself
		b2 = smr_cnt;
		b3 = rdl_cnt;
		i_host.write_reg(`GCCR_OFS_GENERAL, 8'h7e);
		step(12);
		chk(smr_cnt - b2, `GCCR_LOGIC_RST_CYCLES);
		chk(rdl_cnt - b3, 0);
		rdchk(`GCCR_OFS_GENERAL, 8'h7c);
		rdchk(`GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL, 8'h39);
		// Master reset returns both registers to defaults
		b2 = smr_cnt;
		b3 = rdl_cnt;
		i_host.write_reg(`GCCR_OFS_GENERAL, 8'h7d);
		step(16);
		chk(smr_cnt - b2, `GCCR_MASTER_RST_CYCLES);
		chk(rdl_cnt - b3, `GCCR_MASTER_RST_CYCLES);
		chk(cde, 1'b1);
		chk({sl_upd, cl_upd}, 2'b11);
		chk(status_pins, 8'h5a);
		rdchk(`GCCR_OFS_GENERAL, 8'h00);
		rdchk(`GCCR_OFS_CLOCK_RECOVERY_LOOPBACK_CONTROL, 8'h00);
		close_out();
	end
endmodule
